// *** lef_engine_flow.sv ***
// three program engines: end, trigger send/wait, conditional jumps, variable arithmetic
// Function
// - end stops the engine and takes sixteen engine ticks
// - send takes sixteen ticks; wait takes at least sixteen ticks
// - triggers are latched per engine until a wait consumes them
// - wait stalls until every selected source has arrived
// - sent external pulse lasts three engine ticks
// - sync line is active low, driven to ground
// - own sent pulse is never taken as a received trigger
// - send external first, then wait external, in one instruction
// - wait bits 7..9 engines 1..3, bit 12 external
// - send bits 1..3 engines 1..3, bit 6 external
// - true jump skips the encoded count, false goes to next
// - skip count is five bits; zero skips nothing
// - selector 0 A, 1 B, 2 C, 3 register D value
// - A and B per engine, C shared by all
// - load overwrites A, B or C with an immediate
// - add immediate or variables, wraps modulo 256
// - subtract immediate or variables, wraps below zero
`timescale 1ns/1ps
module lef_engine_flow #(
   parameter int NE = lef_pkg::NUM_ENG
) (
   input  wire logic            I_CLK,
   input  wire logic            I_RST_N,
   input  wire logic            I_TICK,
   input  wire logic [NE-1:0]   I_INSTR_VALID,
   input  wire logic [4*NE-1:0] I_INSTR_OP,
   input  wire logic [16*NE-1:0] I_INSTR_WORD,
   input  wire logic [8*NE-1:0] I_VAR_D,
   input  wire logic            I_SYNC_IN,
   output logic                 O_SYNC_OUT,
   output logic                 O_SYNC_OE,
   output logic [NE-1:0]        O_INSTR_READY,
   output logic [NE-1:0]        O_DONE,
   output logic [6*NE-1:0]      O_PC_STEP,
   output logic [NE-1:0]        O_HALT,
   output logic [8*NE-1:0]      O_VAR_A,
   output logic [8*NE-1:0]      O_VAR_B,
   output logic [7:0]           O_VAR_C,
   output logic [4*NE-1:0]      O_EXTERNAL_SYNC_LINE_PEND
);
   lef_sync_if sif ();

   logic [2:0]  send_vec [NE];
   logic [NE-1:0] send_ext;
   logic [NE-1:0] wr_c;
   logic [7:0]  res_val [NE];
   logic [7:0]  c_reg;
   logic [7:0]  c_next;

   function automatic logic [7:0] pick(input logic [1:0] s, input logic [7:0] a, input logic [7:0] b,
                                       input logic [7:0] c, input logic [7:0] d);
      if (s == lef_pkg::SEL_A) return a;
      else if (s == lef_pkg::SEL_B) return b;
      else if (s == lef_pkg::SEL_C) return c;
      else return d;
   endfunction : pick

   lef_sync_line u_line (
      .i_clk      (I_CLK),
      .i_rst_n    (I_RST_N),
      .i_tick     (I_TICK),
      .i_sync_in  (I_SYNC_IN),
      .o_sync_out (O_SYNC_OUT),
      .o_sync_oe  (O_SYNC_OE),
      .sif        (sif)
   );

   // external send issued at instruction start
   assign sif.send_req = |send_ext;

   for (genvar e = 0; e < NE; e++) begin : g_eng
      lef_pkg::lef_st_e state_reg;
      lef_pkg::lef_st_e state_next;
      lef_pkg::lef_op_e op_reg;
      logic [15:0] word_reg;
      logic [4:0]  tick_cnt_reg;
      logic [4:0]  tick_cnt_next;
      logic [3:0]  external_sync_line_reg;
      logic [3:0]  external_sync_line_set;
      logic [3:0]  external_sync_line_clr;
      logic [7:0]  a_reg;
      logic [7:0]  b_reg;
      logic        done_reg;
      logic [5:0]  step_reg;
      logic        halt_reg;

      wire lef_pkg::lef_op_e op_in = lef_pkg::lef_op_e'(I_INSTR_OP[4*e +: 4]);
      wire [15:0] word_in  = I_INSTR_WORD[16*e +: 16];
      wire [7:0]  d_val    = I_VAR_D[8*e +: 8];
      // a halted engine takes nothing until reset
      wire        acc      = (state_reg == lef_pkg::ST_IDLE) && !halt_reg && I_INSTR_VALID[e];
      wire        is_external_sync_line  = (op_reg == lef_pkg::OP_EXTERNAL_SYNC_LINE);
      // wait field layout, bits 10 and 11 ignored
      wire [3:0]  wmask    = {word_reg[lef_pkg::WAIT_EXT_BIT], word_reg[lef_pkg::WAIT_ENG_LSB +: 3]};
      // send field layout, bits 4 and 5 ignored
      wire [2:0]  smask_in = word_in[lef_pkg::SEND_ENG_LSB +: 3];
      wire        sext_in  = word_in[lef_pkg::SEND_EXT_BIT];
      wire        wext_in  = word_in[lef_pkg::WAIT_EXT_BIT];
      wire        ticks_ok = (tick_cnt_reg == lef_pkg::INSTR_TICKS);
      wire        got_all  = ((external_sync_line_reg & wmask) == wmask);
      wire        fin      = (state_reg == lef_pkg::ST_RUN) && ticks_ok && (!is_external_sync_line || got_all);

      wire [1:0]  tgt_imm  = word_reg[lef_pkg::TGT_IMM_LSB +: 2];
      wire [1:0]  tgt_var  = word_reg[lef_pkg::TGT_VAR_LSB +: 2];
      wire [7:0]  imm      = word_reg[lef_pkg::IMM_LSB +: 8];
      wire [7:0]  v1       = pick(word_reg[lef_pkg::V1_LSB +: 2], a_reg, b_reg, c_reg, d_val);
      wire [7:0]  v2       = pick(word_reg[lef_pkg::V2_LSB +: 2], a_reg, b_reg, c_reg, d_val);
      wire [7:0]  vt       = pick(tgt_imm, a_reg, b_reg, c_reg, d_val);
      // five bit skip, zero is harmless
      wire [4:0]  skip     = word_reg[lef_pkg::SKIP_LSB +: 5];
      logic       cond;
      logic [7:0] res;
      logic [1:0] tgt;
      logic       wr;

      always_comb begin
         cond = 1'b0;
         res  = imm;
         tgt  = tgt_imm;
         wr   = 1'b0;
         case (op_reg)
            lef_pkg::OP_JNE:           cond = (v1 != v2);
            lef_pkg::OP_JGE:           cond = (v1 >= v2);
            lef_pkg::OP_JUMP_IF_LESS:  cond = (v1 < v2);
            lef_pkg::OP_JUMP_IF_EQUAL: cond = (v1 == v2);
            lef_pkg::OP_LOAD_VARIABLE: wr = 1'b1;
            lef_pkg::OP_ADDI: begin
               res = vt + imm;
               wr  = 1'b1;
            end
            lef_pkg::OP_ADDV: begin
               res = v1 + v2;
               tgt = tgt_var;
               wr  = 1'b1;
            end
            lef_pkg::OP_SUBI: begin
               res = vt - imm;
               wr  = 1'b1;
            end
            lef_pkg::OP_SUBV: begin
               res = v1 - v2;
               tgt = tgt_var;
               wr  = 1'b1;
            end
            default: wr = 1'b0;
         endcase
      end

      // selector 3 as a target has no storage, so the write is dropped
      wire wr_a = fin && wr && (tgt == lef_pkg::SEL_A);
      wire wr_b = fin && wr && (tgt == lef_pkg::SEL_B);
      assign wr_c[e]    = fin && wr && (tgt == lef_pkg::SEL_C);
      assign res_val[e] = res;

      assign send_vec[e] = (acc && op_in == lef_pkg::OP_EXTERNAL_SYNC_LINE) ? smask_in : 3'h0;
      assign send_ext[e] = acc && op_in == lef_pkg::OP_EXTERNAL_SYNC_LINE && sext_in;

      // latch from all engines, this one included, and line
      always_comb begin
         external_sync_line_set = 4'h0;
         for (int j = 0; j < NE; j++) begin
            external_sync_line_set[j] = send_vec[j][e];
         end
         external_sync_line_set[3] = sif.ext_hit;
      end
      assign external_sync_line_clr = (fin && is_external_sync_line) ? wmask : 4'h0;

      // counter freezes at sixteen; a long wait only holds the state
      always_comb begin
         state_next    = state_reg;
         tick_cnt_next = tick_cnt_reg;
         if (state_reg != lef_pkg::ST_IDLE && I_TICK && !ticks_ok) begin
            tick_cnt_next = tick_cnt_reg + 5'h01;
         end
         case (state_reg)
            lef_pkg::ST_IDLE: begin
               tick_cnt_next = 5'h00;
               if (acc) begin
                  // hold the external wait until own pulse ends
                  state_next = (op_in == lef_pkg::OP_EXTERNAL_SYNC_LINE && sext_in && wext_in) ? lef_pkg::ST_XSEND
                                                                                 : lef_pkg::ST_RUN;
               end
            end
            lef_pkg::ST_XSEND: begin
               if (!sif.busy) begin
                  state_next = lef_pkg::ST_RUN;
               end
            end
            lef_pkg::ST_RUN: begin
               if (fin) begin
                  state_next = lef_pkg::ST_IDLE;
               end
            end
            default: state_next = lef_pkg::ST_IDLE;
         endcase
      end

      always_ff @(posedge I_CLK or negedge I_RST_N) begin
         if (!I_RST_N) begin
            state_reg    <= lef_pkg::ST_IDLE;
            tick_cnt_reg <= 5'h00;
            external_sync_line_reg     <= 4'h0;
         end else begin
            state_reg    <= state_next;
            tick_cnt_reg <= tick_cnt_next;
            // set wins over clear so a same-cycle trigger is kept
            external_sync_line_reg     <= (external_sync_line_reg & ~external_sync_line_clr) | external_sync_line_set;
         end
      end

      // instruction held for the whole execution
      always_ff @(posedge I_CLK or negedge I_RST_N) begin
         if (!I_RST_N) begin
            op_reg   <= lef_pkg::OP_END;
            word_reg <= 16'h0000;
         end else if (acc) begin
            op_reg   <= op_in;
            word_reg <= word_in;
         end
      end

      // private A and B of this engine
      always_ff @(posedge I_CLK or negedge I_RST_N) begin
         if (!I_RST_N) begin
            a_reg <= lef_pkg::VAR_RESET;
         end else if (wr_a) begin
            a_reg <= res;
         end
      end

      always_ff @(posedge I_CLK or negedge I_RST_N) begin
         if (!I_RST_N) begin
            b_reg <= lef_pkg::VAR_RESET;
         end else if (wr_b) begin
            b_reg <= res;
         end
      end

      always_ff @(posedge I_CLK or negedge I_RST_N) begin
         if (!I_RST_N) begin
            done_reg <= 1'b0;
            step_reg <= 6'h00;
         end else begin
            done_reg <= fin;
            if (fin) begin
               step_reg <= cond ? 6'h01 + {1'b0, skip} : 6'h01;
            end
         end
      end

      always_ff @(posedge I_CLK or negedge I_RST_N) begin
         if (!I_RST_N) begin
            halt_reg <= 1'b0;
         end else if (fin && op_reg == lef_pkg::OP_END) begin
            halt_reg <= 1'b1;
         end
      end

      assign O_INSTR_READY[e]     = (state_reg == lef_pkg::ST_IDLE) && !halt_reg;
      assign O_DONE[e]            = done_reg;
      assign O_PC_STEP[6*e +: 6]  = step_reg;
      assign O_HALT[e]            = halt_reg;
      assign O_VAR_A[8*e +: 8]    = a_reg;
      assign O_VAR_B[8*e +: 8]    = b_reg;
      assign O_EXTERNAL_SYNC_LINE_PEND[4*e +: 4] = external_sync_line_reg;
   end

   // simultaneous writes to C: lowest engine wins
   always_comb begin
      c_next = c_reg;
      for (int e = NE - 1; e >= 0; e--) begin
         if (wr_c[e]) begin
            c_next = res_val[e];
         end
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         c_reg <= lef_pkg::VAR_RESET;
      end else begin
         c_reg <= c_next;
      end
   end

   assign O_VAR_C = c_reg;
endmodule : lef_engine_flow

// *** lef_engine_flow_test.sv ***
// self-checking bench for the engine flow block
`timescale 1ns/1ps
module lef_engine_flow_test;
   typedef struct {
      logic [5:0] step;
      logic [1:0] tgt;
      logic [7:0] val;
      logic [3:0] pm;
      logic [3:0] pv;
   } lef_exp_s;
   logic              I_CLK, I_RST_N, I_TICK;
   logic [2:0]        vld;
   logic [11:0]       opv;
   logic [47:0]       wrd;
   logic [23:0]       vd;
   wire  logic        oe, so, pull;
   // pull-up on the shared line: high unless someone pulls
   wire  logic        line = ~(oe | pull);
   wire  logic [2:0]  rdy, done, halt;
   wire  logic [17:0] step;
   wire  logic [23:0] va, vb;
   wire  logic [7:0]  vc;
   wire  logic [11:0] pend;
   int                n_mismatch = 0, checks_done = 0, tk = 0, e;
   logic [7:0]        ma[3], mb[3], mc, im, r;
   logic [1:0]        t, a, b;
   logic [4:0]        sk;
   logic [15:0]       w;
   logic              c;
   lef_pkg::lef_op_e  op;
   lef_exp_s          mx;
   lef_exp_s          q[3][$];

   lef_engine_flow #(.NE(3)) dut_u (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_TICK(I_TICK), .I_INSTR_VALID(vld),
      .I_INSTR_OP(opv), .I_INSTR_WORD(wrd), .I_VAR_D(vd), .I_SYNC_IN(line), .O_SYNC_OUT(so),
      .O_SYNC_OE(oe), .O_INSTR_READY(rdy), .O_DONE(done), .O_PC_STEP(step), .O_HALT(halt),
      .O_VAR_A(va), .O_VAR_B(vb), .O_VAR_C(vc), .O_EXTERNAL_SYNC_LINE_PEND(pend));
   lef_sync_peer peer_u (.i_clk(I_CLK), .i_tick(I_TICK), .o_pull(pull));

   initial begin
      I_CLK = 1'b0;
      forever #2 I_CLK = ~I_CLK;
   end
   // engine tick sped up to one per four clocks to keep the run short
   initial begin
      I_TICK = 1'b0;
      forever begin
         @(posedge I_CLK);
         #1;
         I_TICK = (tk == 3);
         tk = (tk + 1) % 4;
      end
   end

   task automatic cmp(input string nm, input logic [7:0] x, input logic [7:0] g);
      checks_done++;
      if (g !== x) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask : cmp
   task automatic cmpf(input string nm, input logic x, input logic g);
      cmp(nm, {7'h00, x}, {7'h00, g});
   endtask : cmpf
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done
   function automatic logic [7:0] gv(input int k, input logic [1:0] s);
      case (s)
         2'h0: return ma[k];
         2'h1: return mb[k];
         2'h2: return mc;
         default: return vd[8*k +: 8];
      endcase
   endfunction : gv
   task automatic wdone(input int k);
      int n;
      n = 0;
      while (done[k] !== 1'b1 && n < 3000) begin
         @(negedge I_CLK);
         n++;
      end
      if (n >= 3000) cmpf("done", 1'b1, 1'b0);
   endtask : wdone
   // hold the request until ready is seen, then release after the taking edge
   task automatic run(input int k, input lef_pkg::lef_op_e o, input logic [15:0] iw, input lef_exp_s x,
                      input bit wt);
      int n;
      n = 0;
      q[k].push_back(x);
      @(posedge I_CLK);
      #1;
      vld[k] = 1'b1;
      opv[4*k +: 4] = o;
      wrd[16*k +: 16] = iw;
      while (rdy[k] !== 1'b1 && n < 3000) begin
         @(negedge I_CLK);
         n++;
      end
      if (n >= 3000) cmpf("ready", 1'b1, 1'b0);
      @(posedge I_CLK);
      #1;
      vld[k] = 1'b0;
      if (wt) wdone(k);
   endtask : run

   always @(negedge I_CLK) begin
      for (int k = 0; k < 3; k++) begin
         if (done[k] === 1'b1 && q[k].size() > 0) begin
            mx = q[k].pop_front();
            cmp("step", {2'h0, mx.step}, {2'h0, step[6*k +: 6]});
            if (mx.tgt == 2'h0) cmp("var_a", mx.val, va[8*k +: 8]);
            if (mx.tgt == 2'h1) cmp("var_b", mx.val, vb[8*k +: 8]);
            if (mx.tgt == 2'h2) cmp("var_c", mx.val, vc);
            cmp("pend", {4'h0, mx.pv}, {4'h0, pend[4*k +: 4] & mx.pm});
         end else if (done[k] === 1'b1) cmpf("done_extra", 1'b0, 1'b1);
      end
   end

   initial begin
      #100000;
      cmpf("watchdog", 1'b0, 1'b1);
      test_done();
   end

   initial begin
      void'($urandom(32'hECCD));
      vld = 3'h0;
      opv = 12'h000;
      wrd = 48'h0;
      vd = 24'($urandom);
      I_RST_N = 1'b0;
      mc = 8'h00;
      for (int k = 0; k < 3; k++) begin
         ma[k] = 8'h00;
         mb[k] = 8'h00;
      end
      repeat (12) @(posedge I_CLK);
      #1;
      I_RST_N = 1'b1;
      cmp("var_c", 8'h00, vc);
      cmpf("ready", 1'b1, &rdy);
      // send and wait external together: own pulse must not release the wait
      run(0, lef_pkg::OP_EXTERNAL_SYNC_LINE, 16'h1040, '{6'h01, 2'h3, 8'h00, 4'h8, 4'h0}, 1'b0);
      repeat (80) @(posedge I_CLK);
      #1;
      cmpf("ready0", 1'b0, rdy[0]);
      fork
         peer_u.pulse(2);
         wdone(0);
      join
      cmpf("pend_ext", 1'b1, pend[7]);
      // two sources, unused bits set in both fields
      run(1, lef_pkg::OP_EXTERNAL_SYNC_LINE, 16'h0E80, '{6'h01, 2'h3, 8'h00, 4'h5, 4'h0}, 1'b0);
      run(0, lef_pkg::OP_EXTERNAL_SYNC_LINE, 16'h0034, '{6'h01, 2'h3, 8'h00, 4'h0, 4'h0}, 1'b1);
      cmpf("ready1", 1'b0, rdy[1]);
      run(2, lef_pkg::OP_EXTERNAL_SYNC_LINE, 16'h0004, '{6'h01, 2'h3, 8'h00, 4'h0, 4'h0}, 1'b1);
      repeat (80) @(posedge I_CLK);
      for (int i = 0; i < 24; i++) begin
         e = $urandom % 3;
         op = lef_pkg::lef_op_e'(4'(6 + $urandom % 5));
         t = 2'($urandom % 3);
         im = 8'($urandom);
         a = 2'($urandom);
         b = 2'($urandom);
         case (op)
            lef_pkg::OP_LOAD_VARIABLE: r = im;
            lef_pkg::OP_ADDI: r = gv(e, t) + im;
            lef_pkg::OP_SUBI: r = gv(e, t) - im;
            lef_pkg::OP_ADDV: r = gv(e, a) + gv(e, b);
            default: r = gv(e, a) - gv(e, b);
         endcase
         w = (op == lef_pkg::OP_ADDV || op == lef_pkg::OP_SUBV) ? {10'h000, t, a, b} : {6'h00, t, im};
         run(e, op, w, '{6'h01, t, r, 4'h0, 4'h0}, 1'b1);
         if (t == 2'h0) ma[e] = r;
         if (t == 2'h1) mb[e] = r;
         if (t == 2'h2) mc = r;
      end
      for (int i = 0; i < 16; i++) begin
         e = $urandom % 3;
         op = lef_pkg::lef_op_e'(4'(2 + i % 4));
         a = 2'($urandom);
         b = (i < 8) ? a : 2'($urandom);
         sk = (i == 1) ? 5'h00 : (i == 5) ? 5'h1F : 5'($urandom);
         case (op)
            lef_pkg::OP_JNE: c = gv(e, a) != gv(e, b);
            lef_pkg::OP_JGE: c = gv(e, a) >= gv(e, b);
            lef_pkg::OP_JUMP_IF_LESS: c = gv(e, a) < gv(e, b);
            default: c = gv(e, a) == gv(e, b);
         endcase
         run(e, op, {7'h00, sk, a, b}, '{c ? 6'(sk) + 6'h01 : 6'h01, 2'h3, 8'h00, 4'h0, 4'h0}, 1'b1);
      end
      run(0, lef_pkg::OP_END, 16'h0000, '{6'h01, 2'h3, 8'h00, 4'h0, 4'h0}, 1'b1);
      // a halted engine must refuse an offered instruction
      @(posedge I_CLK);
      #1;
      vld[0] = 1'b1;
      opv[3:0] = lef_pkg::OP_LOAD_VARIABLE;
      repeat (80) @(posedge I_CLK);
      #1;
      vld[0] = 1'b0;
      cmpf("halt0", 1'b1, halt[0]);
      cmpf("ready0", 1'b0, rdy[0]);
      for (int k = 0; k < 3; k++) cmp("left", 8'h00, 8'(q[k].size()));
      test_done();
   end
endmodule : lef_engine_flow_test

// *** lef_flow_props.sv ***
// assertion checker on the top ports of the engine flow block
`timescale 1ns/1ps
module lef_flow_props #(
   parameter int NE = lef_pkg::NUM_ENG
) (
   input wire logic              I_CLK,
   input wire logic              I_RST_N,
   input wire logic              I_TICK,
   input wire logic [NE-1:0]     I_INSTR_VALID,
   input wire logic [4*NE-1:0]   I_INSTR_OP,
   input wire logic [16*NE-1:0]  I_INSTR_WORD,
   input wire logic              O_SYNC_OUT,
   input wire logic              O_SYNC_OE,
   input wire logic [NE-1:0]     O_INSTR_READY,
   input wire logic [NE-1:0]     O_DONE,
   input wire logic [NE-1:0]     O_HALT,
   input wire logic [4*NE-1:0]   O_EXTERNAL_SYNC_LINE_PEND
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   logic [4:0] tk_reg;
   logic [3:0] oe_reg;
   logic       xsend;
   // only ticks after the take edge count, so a short instruction is caught
   wire  logic       take0   = I_INSTR_VALID[0] & O_INSTR_READY[0];
   wire  logic [4:0] tk_next = take0 ? 5'h00 : tk_reg + {4'h0, I_TICK & ~&tk_reg};
   wire  logic [3:0] oe_next = O_SYNC_OE ? oe_reg + {3'h0, I_TICK & ~&oe_reg} : 4'h0;
   always_comb begin
      xsend = 1'b0;
      for (int e = 0; e < NE; e++) begin
         xsend = xsend | (I_INSTR_VALID[e] & O_INSTR_READY[e] & I_INSTR_WORD[16*e+lef_pkg::SEND_EXT_BIT]
                 & (I_INSTR_OP[4*e +: 4] == lef_pkg::OP_EXTERNAL_SYNC_LINE));
      end
   end
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tk_reg <= 5'h00;
         oe_reg <= 4'h0;
      end else begin
         tk_reg <= tk_next;
         oe_reg <= oe_next;
      end
   end
   chk_line_drive_low: assert property (O_SYNC_OUT == 1'b0)
      else $error("sync drive value not low");
   chk_send_opens_pulse: assert property ($rose(O_SYNC_OE) |-> $past(xsend))
      else $error("sync pulse without external send");
   chk_pulse_three_ticks: assert property ($fell(O_SYNC_OE) |-> oe_reg == 4'h3)
      else $error("sync pulse length wrong");
   chk_own_pulse_masked: assert property ($rose(O_EXTERNAL_SYNC_LINE_PEND[3]) |-> !$past(O_SYNC_OE))
      else $error("own pulse taken as trigger");
   chk_ext_all_engines: assert property ($rose(O_EXTERNAL_SYNC_LINE_PEND[3]) |-> O_EXTERNAL_SYNC_LINE_PEND[7] && O_EXTERNAL_SYNC_LINE_PEND[11])
      else $error("external trigger not latched by all engines");
   chk_instr_min_ticks: assert property (O_DONE[0] |-> tk_reg >= 5'h10)
      else $error("instruction shorter than sixteen ticks");
   chk_halt_at_done: assert property ($rose(O_HALT[0]) |-> O_DONE[0])
      else $error("halt without instruction finish");
   chk_halt_holds: assert property (O_HALT[0] |=> O_HALT[0] && !O_INSTR_READY[0])
      else $error("halted engine resumed");
   cover property ($fell(O_SYNC_OE));
   cover property ($rose(O_HALT[0]));
   cover property ($rose(O_EXTERNAL_SYNC_LINE_PEND[3]));
endmodule : lef_flow_props

bind lef_engine_flow lef_flow_props #(.NE(NE)) chk_u (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_TICK(I_TICK),
   .I_INSTR_VALID(I_INSTR_VALID), .I_INSTR_OP(I_INSTR_OP), .I_INSTR_WORD(I_INSTR_WORD),
   .O_SYNC_OUT(O_SYNC_OUT), .O_SYNC_OE(O_SYNC_OE), .O_INSTR_READY(O_INSTR_READY), .O_DONE(O_DONE),
   .O_HALT(O_HALT), .O_EXTERNAL_SYNC_LINE_PEND(O_EXTERNAL_SYNC_LINE_PEND));

// *** lef_pkg.sv ***
// shared constants, instruction field layout and types of the engine flow block
package lef_pkg;
   localparam int          NUM_ENG       = 3;
   localparam logic [4:0]  INSTR_TICKS   = 5'h10;
   localparam logic [1:0]  EXT_MIN_LOW   = 2'h2;
   localparam logic [1:0]  EXT_PULSE     = 2'h3;
   localparam logic [7:0]  VAR_RESET     = 8'h00;
   // trigger field positions in the instruction word
   localparam int          WAIT_ENG_LSB  = 7;
   localparam int          WAIT_EXT_BIT  = 12;
   localparam int          SEND_ENG_LSB  = 1;
   localparam int          SEND_EXT_BIT  = 6;
   // jump fields
   localparam int          SKIP_LSB      = 4;
   localparam int          V1_LSB        = 2;
   localparam int          V2_LSB        = 0;
   // load / immediate arithmetic fields
   localparam int          IMM_LSB       = 0;
   localparam int          TGT_IMM_LSB   = 8;
   // variable-form arithmetic target
   localparam int          TGT_VAR_LSB   = 4;
   // operand selector codes
   localparam logic [1:0]  SEL_A         = 2'h0;
   localparam logic [1:0]  SEL_B         = 2'h1;
   localparam logic [1:0]  SEL_C         = 2'h2;
   localparam logic [1:0]  SEL_D         = 2'h3;

   typedef enum logic [3:0] {
      OP_END       = 4'h0,
      OP_EXTERNAL_SYNC_LINE      = 4'h1,
      OP_JNE       = 4'h2,
      OP_JGE       = 4'h3,
      OP_JUMP_IF_LESS  = 4'h4,
      OP_JUMP_IF_EQUAL = 4'h5,
      OP_LOAD_VARIABLE = 4'h6,
      OP_ADDI      = 4'h7,
      OP_ADDV      = 4'h8,
      OP_SUBI      = 4'h9,
      OP_SUBV      = 4'hA
   } lef_op_e;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_RUN   = 3'h2,
      ST_XSEND = 3'h4
   } lef_st_e;
endpackage : lef_pkg

// *** lef_sync_if.sv ***
// carrier between the engine core and the external sync line handler
`timescale 1ns/1ps
interface lef_sync_if;
   logic send_req;
   logic busy;
   logic ext_hit;
   modport core (output send_req, input busy, input ext_hit);
   modport line (input send_req, output busy, output ext_hit);
endinterface : lef_sync_if

// *** lef_sync_line.sv ***
// open-drain external sync line: pulse sender and filtered receiver
`timescale 1ns/1ps
module lef_sync_line (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_tick,
   input  wire logic i_sync_in,
   output logic      o_sync_out,
   output logic      o_sync_oe,
   lef_sync_if.line  sif
);
   logic [1:0] pulse_cnt_reg;
   logic [1:0] pulse_cnt_next;
   logic [1:0] low_cnt_reg;
   logic [1:0] low_cnt_next;
   logic       hit_reg;
   // pin enable straight from a flop, free of decode glitches
   logic       oe_reg;
   wire        driving  = oe_reg;
   // line low means asserted
   wire        line_low = ~i_sync_in;

   // a new request restarts the pulse so overlapping sends merge into one
   // pulse that ends three ticks after the last request
   assign pulse_cnt_next = sif.send_req ? lef_pkg::EXT_PULSE :
                           (driving && i_tick) ? pulse_cnt_reg - 2'h1 : pulse_cnt_reg;
   assign low_cnt_next   = (!line_low || driving) ? 2'h0 :
                           (i_tick && low_cnt_reg != lef_pkg::EXT_MIN_LOW) ? low_cnt_reg + 2'h1 : low_cnt_reg;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pulse_cnt_reg <= 2'h0;
         low_cnt_reg   <= 2'h0;
         hit_reg       <= 1'b0;
         oe_reg        <= 1'b0;
      end else begin
         pulse_cnt_reg <= pulse_cnt_next;
         low_cnt_reg   <= low_cnt_next;
         hit_reg       <= (low_cnt_next == lef_pkg::EXT_MIN_LOW);
         oe_reg        <= (pulse_cnt_next != 2'h0);
      end
   end

   assign o_sync_out  = 1'b0;
   assign o_sync_oe   = driving;
   assign sif.busy    = driving;
   // two low ticks recognised, one hit per low period
   assign sif.ext_hit = (low_cnt_next == lef_pkg::EXT_MIN_LOW) && !hit_reg;
endmodule : lef_sync_line

// *** lef_sync_peer.sv ***
// another device of the same kind on the shared open-drain sync line
`timescale 1ns/1ps
module lef_sync_peer (
   input  wire logic i_clk,
   input  wire logic i_tick,
   output logic      o_pull
);
   initial o_pull = 1'b0;
   task automatic pulse(input int n);
      int k;
      k = 0;
      @(posedge i_clk);
      #1;
      o_pull = 1'b1;
      while (k < n) begin
         @(posedge i_clk);
         if (i_tick) k++;
      end
      #1;
      o_pull = 1'b0;
   endtask : pulse
endmodule : lef_sync_peer
